// ---- include/fsp_pkg.sv ----
// shared constants and types of the fifo serial port
package fsp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_LEAD  = 8'h0C;
  localparam logic [7:0] OFF_RXD   = 8'h10;
  localparam logic [7:0] OFF_TXD   = 8'h14;
  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h10;
  localparam logic [7:0] CTRL1_RST = 8'hC0;
  localparam logic [7:0] FLAGS_RST = 8'h1F;
  localparam logic [7:0] LEAD_RST  = 8'h00;
  // field positions
  localparam int SEL_LSB  = 0;
  localparam int FRST_BIT = 3;
  localparam int IEN_LSB  = 5;
  localparam int CNT_LSB  = 0;
  localparam int RXGO_BIT = 4;
  localparam int TXGO_BIT = 5;
  localparam int FLG_LSB  = 5;
  // fifo size and full byte count
  localparam logic [3:0] FIFO_FULL = 4'h8;
  // half period of shift clock per select code, in clk_i cycles
  localparam logic [63:0] CLK_HALF_DEF = 64'h8040201008040201;
  // transfer sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_GAP  = 3'b001,
    S_LO   = 3'b010,
    S_HI   = 3'b011,
    S_WAIT = 3'b100,
    S_NEXT = 3'b101
  } fsp_state_e;
  // complete state of the port
  typedef struct packed {
    fsp_state_e      st;
    logic [2:0]      sel;
    logic [2:0]      ien;
    logic [3:0]      rx_cnt;
    logic            rx_go;
    logic            tx_go;
    logic [2:0]      flg;
    logic [7:0]      lead;
    logic [7:0][7:0] mem;
    logic [2:0]      wp;
    logic [2:0]      rp;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [2:0]      bit_i;
    logic [3:0]      byte_n;
    logic            is_addr;
    logic            is_rx;
    logic [7:0]      div;
    logic            sclk;
    logic            serial_data_out;
    logic            cs_n;
    logic            rw;
    logic            serial_data_in_m;
    logic            serial_data_in_s;
    logic            wait_m;
    logic            wait_s;
    logic            irq_m;
    logic            irq_s;
    logic            irq_d;
    logic            ack;
    logic [7:0]      rdat;
  } fsp_state_s;
endpackage

// ---- rtl/fsp_fifo_serial_port.sv ----
// fifo serial port: wishbone slave, byte fifo and serial sequencer
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/100ps
module fsp_fifo_serial_port
  import fsp_pkg::*;
#(
  parameter logic [63:0] CLK_HALF = CLK_HALF_DEF
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial link to partner
  output logic             sclk_o,
  output logic             serial_data_out_o,
  input  wire logic        serial_data_in_i,
  output logic             cs_n_o,
  output logic             read_write_ctl_o,
  input  wire logic        busy_i,
  input  wire logic        partner_irq_in_i,
  // interrupt request
  output logic             irq_o
);

  fsp_state_s r;        // registered state
  fsp_state_s n;        // next state
  logic       acc;      // new bus access this cycle
  logic       wr;       // write to low byte lane
  logic       push;     // fifo push request
  logic       pop;      // fifo pop request
  logic [7:0] pdat;     // byte to push
  logic       fclr;     // fifo pointer clear
  logic       abort_c;  // transfer aborted by software
  logic       done_c;   // transfer finished
  logic       expire;   // half period elapsed
  logic [7:0] h;        // half period for selected clock
  logic [3:0] rx_len;   // decoded receive length
  logic       dn_pu;    // push really happens
  logic       dn_po;    // pop really happens

  // next state: bus, synchronisers, sequencer, fifo
  always_comb begin
    n       = r;
    push    = 1'b0;
    pop     = 1'b0;
    pdat    = 8'h00;
    fclr    = 1'b0;
    abort_c = 1'b0;
    done_c  = 1'b0;
    h       = CLK_HALF[{r.sel, 3'h0} +: 8];
    rx_len  = r.rx_cnt[3] ? FIFO_FULL : {1'b0, r.rx_cnt[2:0]};
    expire  = (r.div == 8'h01);
    acc     = wb_cyc_i & wb_stb_i & ~r.ack;
    wr      = acc & wb_we_i & wb_sel_i[0];
    // two-stage pin synchronisers and edge history
    n.serial_data_in_m = serial_data_in_i;
    n.serial_data_in_s = r.serial_data_in_m;
    n.wait_m = busy_i;
    n.wait_s = r.wait_m;
    n.irq_m  = partner_irq_in_i;
    n.irq_s  = r.irq_m;
    n.irq_d  = r.irq_s;
    // bus answer one cycle after the strobe
    n.ack  = acc;
    n.rdat = 8'h00;
    if (acc) begin
      case (wb_adr_i)
        OFF_CTRL0: begin
          n.rdat = {r.ien, CTRL0_RST[4], 1'b0, r.sel};
          if (wr) begin
            n.sel = wb_dat_i[SEL_LSB +: 3];
            n.ien = wb_dat_i[IEN_LSB +: 3];
            fclr  = wb_dat_i[FRST_BIT];
          end
        end
        OFF_CTRL1: begin
          n.rdat = {CTRL1_RST[7:6], r.tx_go, r.rx_go, r.rx_cnt};
          if (wr) begin
            n.rx_cnt = wb_dat_i[CNT_LSB +: 4];
            n.rx_go  = wb_dat_i[RXGO_BIT];
            n.tx_go  = wb_dat_i[TXGO_BIT];
          end
        end
        OFF_FLAGS: begin
          n.rdat = {r.flg, FLAGS_RST[4:0]};
          // writing zero clears a flag, one leaves it
          if (wr) begin
            n.flg = r.flg & wb_dat_i[FLG_LSB +: 3];
          end
        end
        OFF_LEAD: begin
          n.rdat = r.lead;
          if (wr) begin
            n.lead = wb_dat_i[7:0];
          end
        end
        OFF_RXD: begin
          // oldest byte, popped by the read
          n.rdat = r.mem[r.rp];
          pop    = ~wb_we_i;
        end
        OFF_TXD: begin
          push = wr;
          pdat = wb_dat_i[7:0];
        end
        default: begin
          n.rdat = 8'h00;                               // unmapped reads zero
        end
      endcase
    end
    // partner interrupt rising edge, set wins over clear
    if (r.irq_s & ~r.irq_d) begin
      n.flg[0] = 1'b1;
    end
    // half period counter
    // counts down to one and is reloaded by the state that consumes the expiry,
    // except after a byte's last bit, which S_NEXT reloads; so each shift clock half
    // lasts h cycles, except the high between bytes, which also spans the gap
    if (r.st != S_IDLE && !expire) begin
      n.div = r.div - 8'h01;
    end
    // abort when the running direction's start bit is cleared
    if (r.st != S_IDLE && !(r.is_rx ? n.rx_go : n.tx_go)) begin
      abort_c = 1'b1;
      n.st    = S_IDLE;
      n.cs_n  = 1'b1;
      n.rw    = 1'b1;
      n.sclk  = 1'b1;
    end else begin
      case (r.st)
        S_IDLE: begin
          // start: select low, lead address loaded first
          if (n.tx_go | n.rx_go) begin
            n.is_rx   = ~n.tx_go;
            n.cs_n    = 1'b0;
            n.rw      = ~n.tx_go;
            n.sh      = r.lead;
            n.is_addr = 1'b1;
            n.byte_n  = 4'h0;
            n.div     = h;
            n.st      = S_GAP;
          end
        end
        S_GAP: begin
          // idle gap done: first falling edge drives bit 0
          if (expire) begin
            n.sclk  = 1'b0;
            n.serial_data_out = r.sh[0];
            n.bit_i = 3'h0;
            n.div   = h;
            n.st    = S_LO;
          end
        end
        S_LO: begin
          // rising edge: sample receive data lsb first
          if (expire) begin
            n.sclk = 1'b1;
            if (r.is_rx & ~r.is_addr) begin
              n.sh = {r.serial_data_in_s, r.sh[7:1]};
            end
            n.div = h;
            n.st  = S_HI;
          end
        end
        S_HI: begin
          if (expire) begin
            if (r.bit_i == 3'h7) begin
              // whole byte shifted
              if (r.is_addr) begin
                n.is_addr = 1'b0;
                n.st      = S_WAIT;
              end else begin
                if (r.is_rx) begin
                  push     = 1'b1;
                  pdat     = r.sh;
                  n.byte_n = r.byte_n + 4'h1;
                end
                n.st = S_NEXT;
              end
            end else begin
              // falling edge: next bit out
              n.bit_i = r.bit_i + 3'h1;
              n.sclk  = 1'b0;
              n.div   = h;
              n.st    = S_LO;
              if (!(r.is_rx & ~r.is_addr)) begin
                n.sh    = {1'b0, r.sh[7:1]};
                n.serial_data_out = r.sh[1];
              end
            end
          end
        end
        S_WAIT: begin
          // hold while the partner reports busy
          if (!r.wait_s) begin
            n.st = S_NEXT;
          end
        end
        S_NEXT: begin
          if (r.is_rx) begin
            if (r.byte_n == rx_len) begin
              done_c = 1'b1;
            end else begin
              n.div = h;
              n.st  = S_GAP;
            end
          end else if (r.cnt != 4'h0) begin
            pop   = 1'b1;
            n.sh  = r.mem[r.rp];
            n.div = h;
            n.st  = S_GAP;
          end else begin
            done_c = 1'b1;
          end
        end
        default: begin
          n.st = S_IDLE;
        end
      endcase
    end
    // completion: release pins, clear start, set sticky flag
    if (done_c) begin
      n.st   = S_IDLE;
      n.cs_n = 1'b1;
      n.rw   = 1'b1;
      if (r.is_rx) begin
        n.rx_go  = 1'b0;
        n.flg[1] = 1'b1;
      end else begin
        n.tx_go  = 1'b0;
        n.flg[2] = 1'b1;
      end
    end
    // fifo update, full push and empty pop ignored
    // pointers wrap at eight; the separate count tells full from empty,
    // which equal pointers alone could not
    dn_pu = push & (r.cnt != FIFO_FULL);
    dn_po = pop & (r.cnt != 4'h0);
    if (dn_pu) begin
      n.mem[r.wp] = pdat;
      n.wp        = r.wp + 3'h1;
    end
    if (dn_po) begin
      n.rp = r.rp + 3'h1;
    end
    n.cnt = r.cnt + {3'h0, dn_pu} - {3'h0, dn_po};
    if (fclr | abort_c) begin
      n.wp  = 3'h0;
      n.rp  = 3'h0;
      n.cnt = 4'h0;
    end
  end

  // state register with synchronous reset
  // link pins start released: select and rw high, shift clock parked high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r        <= '0;
      r.sel    <= CTRL0_RST[2:0];
      r.ien    <= CTRL0_RST[7:5];
      r.rx_cnt <= CTRL1_RST[3:0];
      r.flg    <= FLAGS_RST[7:5];
      r.lead   <= LEAD_RST;
      r.sclk   <= 1'b1;
      r.cs_n   <= 1'b1;
      r.rw     <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign wb_dat_o          = {24'h000000, r.rdat};
  assign wb_ack_o          = r.ack;
  assign sclk_o            = r.sclk;
  assign serial_data_out_o = r.serial_data_out;
  assign cs_n_o            = r.cs_n;
  assign read_write_ctl_o  = r.rw;
  assign irq_o             = |(r.flg & r.ien);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_after_strobe: assert property (acc |=> wb_ack_o)
    else $error("no ack after strobe");
  a_sclk_idle_high: assert property (cs_n_o |-> sclk_o)
    else $error("shift clock low while deselected");
  a_rw_rx_high: assert property (!cs_n_o && r.is_rx |-> read_write_ctl_o)
    else $error("rw low during receive");
  a_rw_tx_low: assert property (!cs_n_o && !r.is_rx |-> !read_write_ctl_o)
    else $error("rw high during transmit");
  a_fifo_reset_clear: assert property (wr && wb_adr_i == OFF_CTRL0 && wb_dat_i[FRST_BIT]
    |=> r.cnt == 4'h0 && r.rp == 3'h0)
    else $error("fifo not cleared");
  a_tx_done_flag: assert property (done_c && !r.is_rx
    |=> r.flg[2] && !r.tx_go && cs_n_o)
    else $error("tx completion wrong");
  a_rx_done_flag: assert property (done_c && r.is_rx
    |=> r.flg[1] && !r.rx_go && cs_n_o)
    else $error("rx completion wrong");
  a_wait_hold: assert property (r.st == S_WAIT && r.wait_s
    |=> r.st == S_WAIT || r.st == S_IDLE)
    else $error("left wait while busy");
  a_abort_idle: assert property (abort_c |=> cs_n_o && r.st == S_IDLE && r.cnt == 4'h0)
    else $error("abort did not reset port");
  a_ext_edge_irq: assert property ($rose(r.irq_s) && r.ien[0] |=> ##1 irq_o)
    else $error("partner edge gave no request");
  a_rx_push_order: assert property (r.st == S_HI && expire && r.bit_i == 3'h7
    && r.is_rx && !r.is_addr && r.cnt != FIFO_FULL |=> r.cnt == $past(r.cnt) + 4'h1
    || $past(abort_c) || $past(dn_po))
    else $error("received byte not pushed");

  // while paused on the busy input the shift clock must stay parked high,
  // otherwise the partner would see spurious bits before it is ready
  a_wait_sclk_high: assert property (r.st == S_WAIT |-> sclk_o)
    else $error("shift clock moved while paused");

  // select stays low for the whole frame, including gaps and busy pauses;
  // it only rises on the edge that also returns the sequencer to idle
  a_cs_low_busy: assert property (r.st != S_IDLE |-> !cs_n_o)
    else $error("select high during a transfer");

  // the data line may only move together with a falling shift clock,
  // so the partner sampling on the rising edge always sees settled data
  a_serial_data_out_on_fall: assert property ($changed(serial_data_out_o) |-> $fell(sclk_o))
    else $error("data out changed off a falling edge");

  // transmit done is sticky: only a software write of zero removes it
  a_tx_flag_sticky: assert property (r.flg[2]
    && !(wr && wb_adr_i == OFF_FLAGS && !wb_dat_i[FLG_LSB + 2]) |=> r.flg[2])
    else $error("tx flag lost without clear");

  // the byte counter never passes the fifo depth; a push when full is dropped
  a_fifo_bound: assert property (r.cnt <= FIFO_FULL)
    else $error("fifo count above depth");

  // main scenarios: both completions, a full eight byte receive, a busy
  // pause, a software abort and a partner interrupt edge

  c_tx_done: cover property (done_c && !r.is_rx);
  c_rx_done: cover property (done_c && r.is_rx && rx_len == FIFO_FULL);
  c_busy_stall: cover property ((r.st == S_WAIT && r.wait_s) [*3]);
  c_abort: cover property (abort_c);
  c_ext_edge: cover property (r.irq_s && !r.irq_d);

endmodule // fsp_fifo_serial_port

// ---- testbench/fsp_partner_model.sv ----
// behavioural far-side controller for the fifo serial port bench
`timescale 1ns/100ps
module fsp_partner_model (
  // bench clock, times the busy line
  input  wire logic clk_i,
  // serial link from the port
  input  wire logic sclk_i,
  input  wire logic sdo_i,
  input  wire logic cs_n_i,
  input  wire logic rw_i,
  output logic      serial_data_in_o,
  output logic      busy_o,
  output logic      irq_o
);
  logic [7:0] got[$]; // bytes captured in the current frame
  logic [7:0] sh;     // capture shift register
  logic       sclk_d; // shift clock seen at the last clk edge
  int bitc, nby, half, half_min, viol, busy_n;
  bit slow;           // hold busy after the address byte
  initial begin
    {serial_data_in_o, busy_o, irq_o, sh, slow} = '0;
    {bitc, nby, half, viol, busy_n} = '0;
    sclk_d = 1'b1;
    half_min = 999;
  end
  // a frame opens: counters restart
  always @(negedge cs_n_i) begin
    bitc = 0;
    nby = 0;
    half_min = 999;
    got.delete();
  end
  // released data line: never keep the last value
  always @(posedge cs_n_i) serial_data_in_o <= ~serial_data_in_o;
  // capture on rising shift clock, lsb first
  always @(posedge sclk_i) if (!cs_n_i) begin
    sh = {sdo_i, sh[7:1]};
    bitc++;
    if (bitc == 8) begin
      got.push_back(sh);
      bitc = 0;
      nby++;
    end
  end
  // change read data on falling shift clock, lsb first
  always @(negedge sclk_i) if (!cs_n_i) begin
    if (rw_i && nby >= 1) serial_data_in_o <= 8'(8'h3C + 8'h11 * (nby - 1)) >> bitc;
    if (slow && nby == 0 && bitc == 7) busy_o <= 1'b1; // busy around the address end
  end
  // shortest shift clock half, and moves while busy has settled
  always @(posedge clk_i) begin
    half++;
    if (sclk_i !== sclk_d) begin
      if (!cs_n_i && half < half_min) half_min = half;
      if (busy_n > 6) viol++;
      half = 0;
    end
    sclk_d = sclk_i;
    busy_n = busy_o ? busy_n + 1 : 0;
    if (busy_n == 40) busy_o <= 1'b0; // release the pause
  end
  // one interrupt pulse towards the port
  task automatic fire_irq();
    irq_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    irq_o <= 1'b0;
  endtask
endmodule // fsp_partner_model

// ---- testbench/tb.sv ----
// self-checking bench of the fifo serial port
`timescale 1ns/100ps
`define CHK(nm, ex, ob) begin n_checks++; if ((ob) !== (ex)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, ex, ob); end end
module tb;
  import fsp_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic sclk, sdo, serial_data_in, cs_n, rw, busy, pirq, irq;
  int n_fail = 0, n_checks = 0, cyc_n = 0;
  fsp_fifo_serial_port #(.CLK_HALF(CLK_HALF_DEF)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sclk_o(sclk), .serial_data_out_o(sdo), .serial_data_in_i(serial_data_in), .cs_n_o(cs_n),
    .read_write_ctl_o(rw), .busy_i(busy), .partner_irq_in_i(pirq), .irq_o(irq));
  fsp_partner_model u_far (.clk_i(clk_i), .sclk_i(sclk), .sdo_i(sdo), .cs_n_i(cs_n),
    .rw_i(rw), .serial_data_in_o(serial_data_in), .busy_o(busy), .irq_o(pirq));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // one classic wishbone cycle, held until ack
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                         output logic [7:0] rd);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, wd};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] v;
    wb_xfer(1'b1, adr, d, v);
  endtask
  task automatic chk(input logic [7:0] adr, input logic [7:0] ex, input string nm);
    logic [7:0] v;
    wb_xfer(1'b0, adr, 8'h00, v);
    `CHK(nm, ex, v)
  endtask
  // poll until both start bits are clear; data registers untouched meanwhile
  task automatic wait_done();
    logic [7:0] v;
    do wb_xfer(1'b0, OFF_CTRL1, 8'h00, v); while ((v & 8'h30) !== 8'h00);
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    int n;
    logic [3:0] cnt;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'h1;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(OFF_CTRL0, 8'h10, "ctrl0_rst");
    chk(OFF_CTRL1, 8'hC0, "ctrl1_rst");
    chk(OFF_FLAGS, 8'h1F, "flags_rst");
    chk(OFF_LEAD, 8'h00, "lead_rst");
    chk(8'h18, 8'h00, "unmapped");
    // transmit of three bytes with a busy pause
    u_far.slow = 1'b1;
    wr(OFF_CTRL0, 8'h82);
    wr(OFF_LEAD, 8'hA5);
    for (int i = 1; i < 4; i++) wr(OFF_TXD, 8'(8'h11 * i));
    wr(OFF_CTRL1, 8'h20);
    repeat (2) @(posedge clk_i);
    `CHK("cs_tx", 1'b0, cs_n)
    `CHK("rw_tx", 1'b0, rw)
    wait_done();
    `CHK("cs_tx_end", 1'b1, cs_n)
    `CHK("rw_tx_end", 1'b1, rw)
    `CHK("tx_count", 4, u_far.got.size())
    `CHK("tx_lead", 8'hA5, u_far.got[0])
    for (int i = 1; i < 4; i++) `CHK("tx_byte", 8'(8'h11 * i), u_far.got[i])
    `CHK("half_sel2", CLK_HALF_DEF[16+:8], 8'(u_far.half_min))
    `CHK("busy_pause", 0, u_far.viol)
    chk(OFF_CTRL1, 8'hC0, "tx_self_clr");
    chk(OFF_FLAGS, 8'h9F, "flags_tx");
    `CHK("irq_tx", 1'b1, irq)
    wr(OFF_CTRL0, 8'h02);
    `CHK("irq_masked", 1'b0, irq)
    wr(OFF_FLAGS, 8'h00);
    chk(OFF_FLAGS, 8'h1F, "flags_clr");
    u_far.slow = 1'b0;
    // receptions of three bytes and of eight by a top-bit code
    for (int k = 0; k < 2; k++) begin
      cnt = k ? 4'h9 : 4'h3;
      n = cnt[3] ? 8 : int'(cnt);
      wr(OFF_LEAD, 8'h5A);
      wr(OFF_CTRL1, {4'h1, cnt});
      repeat (2) @(posedge clk_i);
      `CHK("cs_rx", 1'b0, cs_n)
      `CHK("rw_rx", 1'b1, rw)
      wait_done();
      `CHK("cs_rx_end", 1'b1, cs_n)
      `CHK("rx_count", n + 1, u_far.nby)
      `CHK("rx_lead", 8'h5A, u_far.got[0])
      chk(OFF_FLAGS, 8'h5F, "flags_rx");
      for (int i = 0; i < n; i++) chk(OFF_RXD, 8'(8'h3C + 8'h11 * i), "rx_byte");
      wr(OFF_FLAGS, 8'h00);
    end
    // fifo pointer reset drops queued bytes, fastest clock select
    wr(OFF_TXD, 8'h77);
    wr(OFF_TXD, 8'h88);
    wr(OFF_CTRL0, 8'h08);
    chk(OFF_CTRL0, 8'h10, "frst_self_clr");
    wr(OFF_CTRL1, 8'h20);
    wait_done();
    `CHK("frst_empty", 1, u_far.got.size())
    `CHK("half_sel0", CLK_HALF_DEF[7:0], 8'(u_far.half_min))
    // aborts of a transmit and of a receive
    wr(OFF_CTRL0, 8'h02);
    wr(OFF_FLAGS, 8'h00);
    for (int i = 0; i < 4; i++) wr(OFF_TXD, 8'h40);
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CTRL1, k ? 8'h14 : 8'h20);
      repeat (60) @(posedge clk_i);
      wr(OFF_CTRL1, 8'h00);
      repeat (2) @(posedge clk_i);
      `CHK("cs_abort", 1'b1, cs_n)
      chk(OFF_FLAGS, 8'h1F, "flags_abort");
    end
    // external request edge, sticky until cleared
    wr(OFF_CTRL0, 8'h22);
    u_far.fire_irq();
    repeat (20) @(posedge clk_i);
    `CHK("irq_ext", 1'b1, irq)
    chk(OFF_FLAGS, 8'h3F, "flags_ext");
    wr(OFF_FLAGS, 8'h00);
    chk(OFF_FLAGS, 8'h1F, "flags_ext_clr");
    stop_test();
  end
endmodule // tb
